// file: rtl/cmag_gate.sv
// Configuration memory access gate: judges each system-zone access.
// Assumes requests arrive from logic on pclk and software uses APB.
//
// How it works
// - Writes, and any key, secret or password access, are judged by the fuse stage; test, revision, serial and forbidden are not.
// - Transport-password regions pass only once that password is validated.
// - After the personalization fuse, a write password unlocks attempt counter and passwords of its set only.
// - Encryption stage: keys, secret, passwords need transport password and encryption.
// - Serial number: reads always open, writes always refused.
// - Crypto region writes need transport password until secrecy fuse, then refused.
// - Fuses program only in order encryption, secrecy, personalization via 01 writes.
// - Reset fuse state: factory fuse zero, other three ones.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module cmag_gate (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic [31:0]               prdata,
   input  wire cmag_pkg::cmag_req_s  req,
   output logic                      resp_valid,
   output logic                      resp_grant,
   output logic [3:0]                fuse_state
);

   cmag_pkg::cmag_state_s state_reg;
   cmag_pkg::cmag_state_s state_next;

   cmag_pkg::cmag_stage_e stage;
   logic                  grant;
   logic                  tp;
   logic                  wpw;
   logic                  done;
   logic [7:0]            fparam;
   logic [7:0]            faddr;
   logic [3:0]            fuse_clr;
   logic [31:0]           rd_word;
   logic                  rd_err;

   // ----------------------------------------------------------------------
   // Fuse stage
   // ----------------------------------------------------------------------
   // The stage follows the last fuse blown; the enforced order keeps it monotone.
   always_comb begin
      if (!state_reg.fuses[cmag_pkg::CMAG_FB_PERSONALIZATION]) begin
         stage = cmag_pkg::CMAG_STG_PERSONAL;
      end else if (!state_reg.fuses[cmag_pkg::CMAG_FB_SECRECY]) begin
         stage = cmag_pkg::CMAG_STG_SECRET;
      end else if (!state_reg.fuses[cmag_pkg::CMAG_FB_ENCRYPTION]) begin
         stage = cmag_pkg::CMAG_STG_ENCRYPT;
      end else begin
         stage = cmag_pkg::CMAG_STG_FACTORY;
      end
   end

   // ----------------------------------------------------------------------
   // Access decision
   // ----------------------------------------------------------------------
   assign tp  = state_reg.transport_ok;
   assign wpw = state_reg.write_password_ok[req.pw_set];

   always_comb begin
      grant = 1'b0;
      case (req.region)
         cmag_pkg::CMAG_RG_MEM_TEST: begin
            grant = 1'b1;
         end
         cmag_pkg::CMAG_RG_HW_REV: begin
            grant = !req.write;
         end
         cmag_pkg::CMAG_RG_SERIAL: begin
            grant = !req.write;
         end
         cmag_pkg::CMAG_RG_ANTICOLL, cmag_pkg::CMAG_RG_ACCESS: begin
            grant = !req.write || (tp && stage != cmag_pkg::CMAG_STG_PERSONAL);
         end
         cmag_pkg::CMAG_RG_NC_OPTION, cmag_pkg::CMAG_RG_CRYPTO: begin
            grant = !req.write || (tp && (stage == cmag_pkg::CMAG_STG_FACTORY ||
                                          stage == cmag_pkg::CMAG_STG_ENCRYPT));
         end
         cmag_pkg::CMAG_RG_KEYS, cmag_pkg::CMAG_RG_SECRET: begin
            case (stage)
               cmag_pkg::CMAG_STG_FACTORY: grant = tp;
               cmag_pkg::CMAG_STG_ENCRYPT: grant = tp && state_reg.encrypt_active;
               default:                    grant = 1'b0;
            endcase
         end
         cmag_pkg::CMAG_RG_PASSWORDS: begin
            case (stage)
               cmag_pkg::CMAG_STG_ENCRYPT:  grant = tp && state_reg.encrypt_active;
               cmag_pkg::CMAG_STG_PERSONAL: grant = wpw;
               default:                     grant = tp;
            endcase
         end
         cmag_pkg::CMAG_RG_ATTEMPT_CNT: begin
            if (!req.write) begin
               grant = 1'b1;
            end else if (stage == cmag_pkg::CMAG_STG_PERSONAL) begin
               grant = wpw;
            end else begin
               grant = tp;
            end
         end
         default: begin
            grant = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------------
   // Read data is built one cycle ahead so that prdata leaves a flip-flop.
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_err  = 1'b0;
      if (paddr == cmag_pkg::CMAG_CTRL_OFS) begin
         rd_word[cmag_pkg::CMAG_CTRL_TP_BIT]      = state_reg.transport_ok;
         rd_word[cmag_pkg::CMAG_CTRL_ENCRYPT_BIT] = state_reg.encrypt_active;
         rd_word[cmag_pkg::CMAG_CTRL_WPW_LSB +: cmag_pkg::CMAG_NSETS] =
            state_reg.write_password_ok;
      end else if (paddr == cmag_pkg::CMAG_FUSE_OFS) begin
         rd_word[3:0] = state_reg.fuses;
      end else if (paddr == cmag_pkg::CMAG_STATUS_OFS) begin
         rd_word[cmag_pkg::CMAG_ST_GRANT_BIT]      = state_reg.last_grant;
         rd_word[cmag_pkg::CMAG_ST_DENY_BIT]       = state_reg.last_deny;
         rd_word[cmag_pkg::CMAG_ST_OERR_BIT]       = state_reg.order_err;
         rd_word[cmag_pkg::CMAG_ST_STAGE_LSB +: 2] = stage;
      end else begin
         rd_err = 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Fuse command decode
   // ----------------------------------------------------------------------
   // Only the next fuse in line is accepted: a skipped stage would lock the
   // configuration before keys and passwords were ever loaded.
   always_comb begin
      fuse_clr = 4'h0;
      if (fparam == cmag_pkg::CMAG_FUSE_PARAM_PGM) begin
         if (faddr == cmag_pkg::CMAG_FUSE_ADDR_ENCRYPT &&
             stage == cmag_pkg::CMAG_STG_FACTORY) begin
            fuse_clr[cmag_pkg::CMAG_FB_ENCRYPTION] = 1'b1;
         end else if (faddr == cmag_pkg::CMAG_FUSE_ADDR_SECRECY &&
                      stage == cmag_pkg::CMAG_STG_ENCRYPT) begin
            fuse_clr[cmag_pkg::CMAG_FB_SECRECY] = 1'b1;
         end else if (faddr == cmag_pkg::CMAG_FUSE_ADDR_PERSONAL &&
                      stage == cmag_pkg::CMAG_STG_SECRET) begin
            fuse_clr[cmag_pkg::CMAG_FB_PERSONALIZATION] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Next state: APB slave, fuse programming, request answer
   // ----------------------------------------------------------------------
   // One wait state per transfer so that prdata can come from a flip-flop.
   assign done   = psel && penable && state_reg.pready;
   assign fparam = pwdata[cmag_pkg::CMAG_FUSE_PARAM_LSB +: 8];
   assign faddr  = pwdata[cmag_pkg::CMAG_FUSE_ADDR_LSB +: 8];

   always_comb begin
      state_next            = state_reg;
      state_next.pready     = psel && penable && !state_reg.pready;
      state_next.pslverr    = 1'b0;
      state_next.resp_valid = req.valid;
      state_next.resp_grant = req.valid && grant;
      if (req.valid) begin
         state_next.last_grant = grant;
         state_next.last_deny  = !grant;
      end

      if (psel && penable && !state_reg.pready) begin
         state_next.prdata  = rd_word;
         state_next.pslverr = rd_err;
      end

      if (done && pwrite) begin
         if (paddr == cmag_pkg::CMAG_CTRL_OFS) begin
            state_next.transport_ok   = pwdata[cmag_pkg::CMAG_CTRL_TP_BIT];
            state_next.encrypt_active = pwdata[cmag_pkg::CMAG_CTRL_ENCRYPT_BIT];
            state_next.write_password_ok    =
               pwdata[cmag_pkg::CMAG_CTRL_WPW_LSB +: cmag_pkg::CMAG_NSETS];
         end else if (paddr == cmag_pkg::CMAG_FUSE_OFS) begin
            // Out-of-order or malformed commands leave the fuses alone
            state_next.fuses     = state_reg.fuses & ~fuse_clr;
            state_next.order_err = (fuse_clr == 4'h0);
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Fuses model one-time cells; a real part would load them from NVM.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg       <= '0;
         state_reg.fuses <= cmag_pkg::CMAG_FUSE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pready     = state_reg.pready;
   assign pslverr    = state_reg.pslverr;
   assign prdata     = state_reg.prdata;
   assign resp_valid = state_reg.resp_valid;
   assign resp_grant = state_reg.resp_grant;
   assign fuse_state = state_reg.fuses;

endmodule // cmag_gate

`default_nettype wire

// file: rtl/cmag_pkg.sv
// Package for the configuration memory access gate.
// Assumes a single 200 MHz clock domain and an APB master for software.
package cmag_pkg;

   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] CMAG_CTRL_OFS   = 8'h00;
   localparam logic [7:0] CMAG_FUSE_OFS   = 8'h04;
   localparam logic [7:0] CMAG_STATUS_OFS = 8'h08;

   // CTRL fields
   localparam int CMAG_CTRL_TP_BIT      = 0;
   localparam int CMAG_CTRL_ENCRYPT_BIT = 1;
   localparam int CMAG_CTRL_WPW_LSB     = 8;

   // FUSE fields: read shows fuse byte, write programs one fuse
   localparam int CMAG_FUSE_ADDR_LSB  = 0;
   localparam int CMAG_FUSE_PARAM_LSB = 8;
   localparam logic [7:0] CMAG_FUSE_PARAM_PGM     = 8'h01;
   localparam logic [7:0] CMAG_FUSE_ADDR_ENCRYPT  = 8'h06;
   localparam logic [7:0] CMAG_FUSE_ADDR_SECRECY  = 8'h04;
   localparam logic [7:0] CMAG_FUSE_ADDR_PERSONAL = 8'h00;

   // Fuse byte bit positions
   localparam int CMAG_FB_PERSONALIZATION = 0;
   localparam int CMAG_FB_SECRECY         = 1;
   localparam int CMAG_FB_ENCRYPTION      = 2;
   localparam int CMAG_FB_FACTORY_LOCK    = 3;
   localparam logic [3:0] CMAG_FUSE_RESET = 4'h7;

   // STATUS fields
   localparam int CMAG_ST_GRANT_BIT = 0;
   localparam int CMAG_ST_DENY_BIT  = 1;
   localparam int CMAG_ST_OERR_BIT  = 2;
   localparam int CMAG_ST_STAGE_LSB = 4;

   localparam int CMAG_NSETS = 4;
   localparam int CMAG_SETW  = 2;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      CMAG_RG_ANTICOLL, CMAG_RG_MEM_TEST, CMAG_RG_HW_REV, CMAG_RG_SERIAL,
      CMAG_RG_ACCESS, CMAG_RG_NC_OPTION, CMAG_RG_CRYPTO, CMAG_RG_KEYS,
      CMAG_RG_SECRET, CMAG_RG_PASSWORDS, CMAG_RG_ATTEMPT_CNT, CMAG_RG_FORBIDDEN
   } cmag_region_e;

   typedef enum logic [1:0] {
      CMAG_STG_FACTORY, CMAG_STG_ENCRYPT, CMAG_STG_SECRET, CMAG_STG_PERSONAL
   } cmag_stage_e;

   typedef struct packed {
      logic                  valid;
      cmag_region_e          region;
      logic                  write;
      logic [CMAG_SETW-1:0]  pw_set;
   } cmag_req_s;

   typedef struct packed {
      logic                   pready;
      logic                   pslverr;
      logic [31:0]            prdata;
      logic [3:0]             fuses;
      logic                   transport_ok;
      logic                   encrypt_active;
      logic [CMAG_NSETS-1:0]  write_password_ok;
      logic                   resp_valid;
      logic                   resp_grant;
      logic                   last_grant;
      logic                   last_deny;
      logic                   order_err;
   } cmag_state_s;

endpackage

// file: sim/cmag_properties.sv
// Assertions on the gate's request and fuse ports.
// Assumes one pclk domain and an async active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module cmag_properties (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire cmag_pkg::cmag_req_s req,
   input wire logic                resp_valid,
   input wire logic                resp_grant,
   input wire logic [3:0]          fuse_state
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Request that the current response judges
   cmag_pkg::cmag_req_s rq;
   always_ff @(posedge pclk) rq <= req;
   resp_timing_a: assert property (resp_valid == $past(req.valid))
      else $error("response timing");
   test_open_a: assert property (resp_valid && rq.region == cmag_pkg::CMAG_RG_MEM_TEST
      |-> resp_grant) else $error("test area refused");
   forbid_reg_a: assert property (resp_valid && rq.region >= cmag_pkg::CMAG_RG_FORBIDDEN
      |-> !resp_grant) else $error("forbidden granted");
   serial_ro_a: assert property (resp_valid && rq.write
      && rq.region == cmag_pkg::CMAG_RG_SERIAL |-> !resp_grant) else $error("serial written");
   key_lock_a: assert property (resp_valid && !$past(fuse_state[1])
      && rq.region inside {cmag_pkg::CMAG_RG_KEYS, cmag_pkg::CMAG_RG_SECRET}
      |-> !resp_grant) else $error("key or secret after lock");
   crypto_lock_a: assert property (resp_valid && rq.write && !$past(fuse_state[1])
      && rq.region == cmag_pkg::CMAG_RG_CRYPTO |-> !resp_grant) else $error("crypto written");
   fuse_reset_a: assert property (!$past(presetn) |-> fuse_state == 4'h7)
      else $error("fuse default wrong");
   fuse_order_a: assert property (fuse_state inside {4'h7, 4'h3, 4'h1, 4'h0})
      else $error("fuse order broken");
   cover property (resp_valid && resp_grant && rq.region == cmag_pkg::CMAG_RG_KEYS);
   cover property (resp_valid && resp_grant && fuse_state == 4'h0);
   cover property (resp_valid && !resp_grant && fuse_state == 4'h1);
endmodule // cmag_properties
bind cmag_gate cmag_properties u_props (.pclk, .presetn, .req, .resp_valid,
   .resp_grant, .fuse_state);
`default_nettype wire

// file: sim/cmag_reader.sv
// Reader model: one system-zone access per call of ask.
// Assumes ask is called just after a rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module cmag_reader (
   input  wire logic                pclk,
   input  wire logic                presetn,
   output var  cmag_pkg::cmag_req_s req,
   input  wire logic                resp_valid,
   input  wire logic                resp_grant
);
   initial req = '0;
   task automatic ask(input logic [3:0] r, input logic w, input logic [1:0] s,
      input logic slow, output logic [1:0] vg);
      if (slow) @(posedge pclk);
      req <= '{1'b1, cmag_pkg::cmag_region_e'(r), w, s};
      @(posedge pclk);
      // Released fields flip so stale values never pass for a request
      req <= '{1'b0, cmag_pkg::cmag_region_e'(~r), ~w, ~s};
      @(posedge pclk);
      vg = {resp_valid, resp_grant};
   endtask
endmodule // cmag_reader
`default_nettype wire

// file: sim/config_memory_access_gate_tb.sv
// Self-checking bench: APB software plus the reader model.
// Assumes package, gate, reader and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module config_memory_access_gate_tb;
   logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic                pready, pslverr, e, resp_valid, resp_grant;
   logic [1:0]          vg, x;
   logic [3:0]          fuse_state;
   logic [7:0]          paddr = 8'h00, fa [3] = '{8'h06, 8'h04, 8'h00};
   logic [31:0]         pwdata = 32'h0, prdata, rd, c, q;
   cmag_pkg::cmag_req_s req;
   int                  bad_count = 0, checks = 0, st, i;
   always #2.5 pclk = ~pclk;
   cmag_gate uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .pslverr, .prdata, .req, .resp_valid, .resp_grant, .fuse_state);
   cmag_reader rdr (.pclk, .presetn, .req, .resp_valid, .resp_grant);
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, x);
      checks++;
      if (s !== x) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask
   // Idle edge at the end so strobes never change twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      repeat (20) if (pready !== 1'b1) @(posedge pclk);
      chk("pready", pready, 1'b1);
      if (pready !== 1'b1) complete_run();
      {e, rd} = {pslverr, prdata};
      {psel, penable} <= 2'b00;
      @(posedge pclk);
   endtask
   function automatic logic exp_g(input int st, input logic [3:0] r, input logic w, t, n, p);
      case (r)
         4'h0, 4'h4: return !w || (st < 3 && t);
         4'h1: return 1'b1;
         4'h2, 4'h3: return !w;
         4'h5, 4'h6: return !w || (st < 2 && t);
         4'h7, 4'h8: return st == 0 ? t : st == 1 && t && n;
         4'h9: return st == 3 ? p : st == 1 ? t && n : t;
         4'hA: return !w || (st < 3 ? t : p);
         default: return 1'b0;
      endcase
   endfunction
   initial begin
      c = $urandom(5261);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped error", e, 1'b1);
      chk("unmapped data", rd, 32'h0);
      $display("register map test done");
      for (st = 0; st < 4; st++) begin
         apb(1'b0, 8'h04, 32'h0);
         chk("fuse byte", rd[3:0], 4'h7 >> st);
         chk("fuse pins", fuse_state, 4'h7 >> st);
         apb(1'b0, 8'h08, 32'h0);
         chk("status", rd[5:0], {2'(st), 2'b00, ((st == 0) ? 2'b00 : {~x[0], x[0]})});
         for (i = 0; i < 150; i++) begin
            c = $urandom & 32'h0F03;
            q = $urandom;
            apb(1'b1, 8'h00, c);
            apb(1'b0, 8'h00, 32'h0);
            chk("ctrl readback", rd, c);
            rdr.ask(q[3:0], q[4], q[6:5], q[7], vg);
            x = {1'b1, exp_g(st, q[3:0], q[4], c[0], c[1], c[8 + q[6:5]])};
            chk("grant", vg, x);
         end
         if (st < 3) begin
            apb(1'b1, 8'h04, {16'h0, 8'h01, fa[(st + 1) % 3]});
            apb(1'b0, 8'h08, 32'h0);
            chk("order error", rd[2], 1'b1);
            apb(1'b1, 8'h04, {16'h0, 8'h02, fa[st]});
            apb(1'b0, 8'h04, 32'h0);
            chk("param refused", rd[3:0], 4'h7 >> st);
            apb(1'b1, 8'h04, {16'h0, 8'h01, fa[st]});
         end
         $display("fuse stage %0d test done", st);
      end
      complete_run();
   end
endmodule // config_memory_access_gate_tb
`default_nettype wire
